/* File: bpcc_top.sv */
// Purpose: parity generation, checking, error latching and control register
// Assumes: bus pins sampled through three flops; register port strobes on same clock
// Notes: only the control register is mapped here; other board maps are elsewhere
module bpcc_top (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_bus_reset_n,
	input wire bpcc_pkg::bpcc_bus_t i_bus,
	input wire logic i_as_n,
	input wire logic i_ds_n,
	input wire logic i_dtack_n,
	input wire logic i_block_mode,
	input wire logic i_involved_write,
	input wire logic i_involved_read,
	input wire logic i_board_driven,
	input wire logic [31:2] i_base_switch,
	input wire logic i_reg_sel_a24,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [31:0] i_reg_wdata,
	input wire logic [31:0] i_out_addr,
	input wire logic [5:0] i_out_am,
	input wire logic [31:0] i_out_data,
	input wire logic i_board_wants_fe,
	output logic [31:0] o_reg_rdata,
	output logic o_reg_hit,
	output logic [3:0] o_out_addr_par,
	output logic o_out_am_par,
	output logic [3:0] o_out_data_par,
	output logic o_fe_error_irq,
	output logic o_fe_access_ok
);
	// ----------------------------------------
	// parity helper
	// ----------------------------------------
	function automatic logic [3:0] odd_par32(input logic [31:0] v);
		logic [3:0] p;
		p = '0;
		for (int i = 0; i < 4; i++) begin
			p[i] = ~(^v[8*i +: 8]);
		end
		return p;
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] as_s, ds_s, dt_s, rst_s;
	logic as_act, ds_act, dt_act, brst;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			as_s <= 3'h0;
			ds_s <= 3'h0;
			dt_s <= 3'h0;
			rst_s <= 3'h0;
		end else begin
			as_s <= {as_s[1:0], ~i_as_n};
			ds_s <= {ds_s[1:0], ~i_ds_n};
			dt_s <= {dt_s[1:0], ~i_dtack_n};
			rst_s <= {rst_s[1:0], ~i_bus_reset_n};
		end
	end
	// a change counts once stages two and three agree
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			as_act <= 1'b0;
			ds_act <= 1'b0;
			dt_act <= 1'b0;
			brst <= 1'b0;
		end else begin
			if (as_s[1] == as_s[2]) as_act <= as_s[2];
			if (ds_s[1] == ds_s[2]) ds_act <= ds_s[2];
			if (dt_s[1] == dt_s[2]) dt_act <= dt_s[2];
			if (rst_s[1] == rst_s[2]) brst <= rst_s[2];
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	logic [4:0] ctrl;
	logic dperr, aperr, as_prev, burst_seen;
	wire hit = (i_bus.addr[31:2] == i_base_switch) |
		(i_reg_sel_a24 & (i_bus.addr[23:2] == i_base_switch[23:2]));
	wire wr_en = i_reg_wr & hit;
	wire clr = wr_en & i_reg_wdata[bpcc_pkg::CLR_BIT];
	wire force_on = ctrl[bpcc_pkg::FORCE_BIT];
	wire fsel = ctrl[bpcc_pkg::FSEL_BIT];
	wire gchk = ctrl[bpcc_pkg::GCHK_BIT];
	wire repen = ctrl[bpcc_pkg::REPEN_BIT];
	wire gate = ctrl[bpcc_pkg::GATE_BIT];

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl <= bpcc_pkg::CTRL_RESET;
		end else if (brst) begin
			ctrl <= bpcc_pkg::CTRL_RESET;
		end else if (wr_en) begin
			ctrl <= i_reg_wdata[4:0];
		end
	end

	// ----------------------------------------
	// parity checking
	// ----------------------------------------
	wire [3:0] a_exp = odd_par32(i_bus.addr);
	wire am_exp = ~(^{2'h0, i_bus.am});
	wire [3:0] d_exp = odd_par32(i_bus.data);
	wire a_bad = (a_exp != i_bus.addr_par) | (am_exp != i_bus.am_par);
	wire d_bad = d_exp != i_bus.data_par;
	wire first_addr = as_act & ~(i_block_mode & burst_seen);
	wire d_window = (i_involved_write & ds_act) | (i_involved_read & dt_act);
	wire d_chk_ok = ~(i_board_driven & ~gchk);
	wire a_evt = first_addr & a_bad;
	wire d_evt = d_window & d_chk_ok & d_bad;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			burst_seen <= 1'b0;
			as_prev <= 1'b0;
		end else begin
			as_prev <= as_act;
			burst_seen <= as_act & (burst_seen | as_prev);
		end
	end

	// set wins over clear so an error in the clear cycle is kept
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dperr <= 1'b0;
			aperr <= 1'b0;
		end else if (brst) begin
			dperr <= 1'b0;
			aperr <= 1'b0;
		end else begin
			dperr <= d_evt | (dperr & ~clr);
			aperr <= a_evt | (aperr & ~clr);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	wire force_d = force_on & fsel;
	wire force_a = force_on & ~fsel;
	wire [31:0] rd_word = {20'h0, 1'b0, 4'h0, dperr, aperr, ctrl};

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 32'h0;
			o_out_addr_par <= 4'h0;
			o_out_am_par <= 1'b0;
			o_out_data_par <= 4'h0;
			o_fe_error_irq <= 1'b0;
			o_fe_access_ok <= 1'b0;
		end else begin
			o_reg_rdata <= (i_reg_rd & hit) ? rd_word : 32'h0;
			o_out_addr_par <= odd_par32(i_out_addr) ^ {4{force_a}};
			o_out_am_par <= ~(^i_out_am) ^ force_a;
			o_out_data_par <= odd_par32(i_out_data) ^ {4{force_d}};
			o_fe_error_irq <= repen & (dperr | aperr);
			o_fe_access_ok <= i_board_wants_fe & ~gate;
		end
	end
	assign o_reg_hit = hit & (i_reg_wr | i_reg_rd);

	// ----------------------------------------
	// checks: error latches
	// ----------------------------------------
	a_clear_both: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		clr && !d_evt && !a_evt |=> !dperr && !aperr)
		else $error("clear did not reset flags");
	a_data_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		dperr && !clr && !brst |=> dperr)
		else $error("data flag lost");
	a_data_set: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		d_evt && !brst |=> dperr)
		else $error("data error not latched");
	a_reset_flags: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		brst |=> !dperr && !aperr)
		else $error("flags survive bus reset");
	a_addr_set: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		a_evt && !brst |=> aperr)
		else $error("address error not latched");
	a_no_window: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!dperr && !d_window |=> !dperr || $past(brst))
		else $error("data flag set outside window");
	a_addr_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		aperr && !clr && !brst |=> aperr)
		else $error("address flag lost");
	a_addr_window: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!aperr && !as_act |=> !aperr)
		else $error("address flag set without strobe");
	// burst_seen lags the strobe by two cycles, so the first address is looked at twice
	a_block_skip: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!aperr && as_act && i_block_mode && burst_seen |=> !aperr)
		else $error("later block address checked");
	a_burst_track: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!as_act |=> !burst_seen)
		else $error("burst state outlives strobe");
	a_am_only: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		first_addr && (am_exp != i_bus.am_par) && !brst |=> aperr)
		else $error("modifier error not latched");
	a_ds_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!dperr && !i_involved_read && !ds_act |=> !dperr)
		else $error("write side checked without data strobe");
	a_dtack_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!dperr && !i_involved_write && !dt_act |=> !dperr)
		else $error("read side checked without acknowledge");
	a_gchk_on: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		d_window && gchk && d_bad && !brst |=> dperr)
		else $error("enabled check missed an error");
	a_gchk_mask: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!dperr && i_board_driven && !gchk |=> !dperr)
		else $error("board data checked while suppressed");
	a_addr_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		clr && !a_evt |=> !aperr)
		else $error("address flag not cleared");
	a_data_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		clr && !d_evt |=> !dperr)
		else $error("data flag not cleared");

	// ----------------------------------------
	// checks: outgoing parity
	// ----------------------------------------
	a_force_data: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		force_d |=> o_out_data_par != odd_par32($past(i_out_data)))
		else $error("data parity not forced");
	a_force_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		force_a |=> o_out_addr_par == ~odd_par32($past(i_out_addr)))
		else $error("address parity not forced");
	a_force_am: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		force_a |=> o_out_am_par == ^$past(i_out_am))
		else $error("modifier parity not forced");
	a_plain_data: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!force_d |=> o_out_data_par == odd_par32($past(i_out_data)))
		else $error("data parity wrong");
	a_plain_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!force_a |=> o_out_addr_par == odd_par32($past(i_out_addr)))
		else $error("address parity wrong");
	a_plain_am: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!force_a |=> o_out_am_par == ~^$past(i_out_am))
		else $error("modifier parity wrong");
	a_fsel_data: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		force_on && fsel |=> o_out_addr_par == odd_par32($past(i_out_addr)))
		else $error("address corrupted when data selected");
	a_fsel_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		force_on && !fsel |=> o_out_data_par == odd_par32($past(i_out_data)))
		else $error("data corrupted when address selected");

	// ----------------------------------------
	// checks: register port
	// ----------------------------------------
	a_read_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_reg_rd |=> o_reg_rdata[31:7] == 25'h0)
		else $error("unused bits read nonzero");
	a_unmapped_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_reg_rd && !hit |=> o_reg_rdata == 32'h0)
		else $error("unmapped read returned data");
	a_read_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!i_reg_rd |=> o_reg_rdata == 32'h0)
		else $error("read data without a read");
	a_write_lands: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		wr_en && !brst |=> ctrl == 5'($past(i_reg_wdata)))
		else $error("control write lost");
	a_clear_reads_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_reg_rd |=> !o_reg_rdata[bpcc_pkg::CLR_BIT])
		else $error("clear bit reads one");
	a_reset_ctrl: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		brst |=> ctrl == bpcc_pkg::CTRL_RESET)
		else $error("control bits survive bus reset");
	a_flags_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_reg_rd && hit |=> o_reg_rdata[6:5] == {$past(dperr), $past(aperr)})
		else $error("flags read wrong");
	a_ctrl_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!wr_en && !brst |=> $stable(ctrl))
		else $error("control bits changed without a write");

	// ----------------------------------------
	// checks: interrupt and access gate
	// ----------------------------------------
	a_irq_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!repen |=> !o_fe_error_irq)
		else $error("interrupt raised while reporting off");
	a_irq_raise: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		repen && (dperr || aperr) |=> o_fe_error_irq)
		else $error("reported error raised no interrupt");
	a_irq_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!dperr && !aperr |=> !o_fe_error_irq)
		else $error("interrupt without an error");
	// the interrupt sits one register behind the flags, hence the extra cycle
	a_irq_bus_reset: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		brst |=> ##1 !o_fe_error_irq)
		else $error("interrupt survives bus reset");
	a_gate_block: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		gate |=> !o_fe_access_ok)
		else $error("front-end access while gated");
	a_gate_open: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_board_wants_fe && !gate |=> o_fe_access_ok)
		else $error("front-end access refused while open");
	a_fe_request: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!i_board_wants_fe |=> !o_fe_access_ok)
		else $error("front-end access without request");
endmodule

/* File: bpcc_pkg.sv */
// Purpose: constants and types for the bus parity check and control register block
// Assumes: one 200 MHz clock, asynchronous active-low reset
// Notes: register fields are bit positions within the 32-bit control word
package bpcc_pkg;
	localparam int unsigned CLR_BIT = 11;
	localparam int unsigned DPERR_BIT = 6;
	localparam int unsigned APERR_BIT = 5;
	localparam int unsigned FSEL_BIT = 4;
	localparam int unsigned FORCE_BIT = 3;
	localparam int unsigned GCHK_BIT = 2;
	localparam int unsigned REPEN_BIT = 1;
	localparam int unsigned GATE_BIT = 0;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam int unsigned SYNC_DEPTH = 3;

	// bus side of one cycle, as seen on the parity-protected bus
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0] addr_par;
		logic [5:0] am;
		logic am_par;
		logic [31:0] data;
		logic [3:0] data_par;
	} bpcc_bus_t;

	// strobes as synchronised levels
	typedef struct packed {
		logic as_act;
		logic ds_act;
		logic dtack_act;
		logic block_mode;
		logic involved_write;
		logic involved_read;
		logic board_driven;
	} bpcc_strobe_t;
endpackage

/* File: bpcc_bus_agent.sv */
// Purpose: far-side bus agent that drives one cycle with per-byte parity
// Assumes: the bench holds the fields steady while strobes are active
// Notes: bad flags invert parity, so every error on the bus is deliberate
module bpcc_bus_agent (
	input wire logic [31:0] i_addr,
	input wire logic [5:0] i_am,
	input wire logic [31:0] i_data,
	input wire logic i_bad_addr,
	input wire logic i_bad_data,
	output bpcc_pkg::bpcc_bus_t o_bus
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb begin
		o_bus.addr = i_addr;
		o_bus.am = i_am;
		o_bus.data = i_data;
		for (int i = 0; i < 4; i++) begin
			o_bus.addr_par[i] = ~^i_addr[8*i +: 8] ^ i_bad_addr;
			o_bus.data_par[i] = ~^i_data[8*i +: 8] ^ i_bad_data;
		end
		o_bus.am_par = ~^i_am ^ i_bad_addr;
	end
endmodule

/* File: bpcc_top_test.sv */
// Purpose: self-checking bench for the parity check and control register block
// Assumes: 200 MHz clock, reset held for 10 cycles
// Notes: strobes pass a four-cycle sync, so every strobe and bus reset is held at least eight cycles
module bpcc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] BASE = 32'h00c0_0010;
	typedef struct packed {logic [4:0] ctrl; logic fa; logic fd; logic fe;} bpcc_row_t;
	logic clk = 1'b0, rst_n = 1'b0, brst_n = 1'b1, wr = 1'b0, rd = 1'b0;
	logic inv_w = 1'b0, inv_r = 1'b0, bdrv = 1'b0, bad_a = 1'b0, bad_d = 1'b0;
	logic blk = 1'b0, a24 = 1'b0;
	logic [2:0] stb_n = 3'h7;
	logic [31:0] addr = BASE, wdata = 32'h0, oaddr = 32'h0, odata = 32'h0, rdata;
	logic [5:0] oam = 6'h00;
	logic hit, am_par, irq, fe_ok;
	logic [3:0] a_par, d_par;
	bpcc_pkg::bpcc_bus_t bus;
	int err_total = 0, checks = 0;
	bpcc_row_t rows [5] = '{{5'h00, 1'b0, 1'b0, 1'b1}, {5'h08, 1'b1, 1'b0, 1'b1},
		{5'h18, 1'b0, 1'b1, 1'b1}, {5'h10, 1'b0, 1'b0, 1'b1}, {5'h01, 1'b0, 1'b0, 1'b0}};
	bpcc_bus_agent bpcc_bus_agent_i (.i_addr(addr), .i_am(6'h0d), .i_data(32'h5a5a_0f01),
		.i_bad_addr(bad_a), .i_bad_data(bad_d), .o_bus(bus));
	bpcc_top bpcc_top_i (.i_clk_sys(clk), .i_rst_n(rst_n), .i_bus_reset_n(brst_n), .i_bus(bus),
		.i_as_n(stb_n[2]), .i_ds_n(stb_n[1]), .i_dtack_n(stb_n[0]), .i_block_mode(blk),
		.i_involved_write(inv_w), .i_involved_read(inv_r), .i_board_driven(bdrv),
		.i_base_switch(BASE[31:2]), .i_reg_sel_a24(a24), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_wdata(wdata), .i_out_addr(oaddr), .i_out_am(oam), .i_out_data(odata),
		.i_board_wants_fe(1'b1), .o_reg_rdata(rdata), .o_reg_hit(hit), .o_out_addr_par(a_par),
		.o_out_am_par(am_par), .o_out_data_par(d_par), .o_fe_error_irq(irq), .o_fe_access_ok(fe_ok));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	function automatic logic [31:0] par4(input logic [31:0] v, input logic inv);
		for (int i = 0; i < 4; i++) par4[i] = ~^v[8*i +: 8] ^ inv;
		par4[31:4] = 28'h0;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic reg_wr(input logic [31:0] v);
		@(posedge clk);
		addr <= BASE;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [31:0] a, input logic [31:0] v, input logic h);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		#1 chk({31'h0, hit}, {31'h0, h});
		@(posedge clk);
		rd <= 1'b0;
		addr <= BASE;
		#1 chk(rdata, v);
		@(posedge clk);
	endtask
	// a strobe held long enough to pass the sync, then released
	task automatic strobe(input logic [2:0] s);
		@(posedge clk);
		stb_n <= ~s;
		repeat (8) @(posedge clk);
		stb_n <= 3'h7;
		repeat (8) @(posedge clk);
	endtask
	task automatic end_of_test();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		forever #2.5 clk = ~clk;
	end
	initial begin
		#20us;
		err_total++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		reg_rd(BASE, 32'h0, 1'b1);
		reg_wr(32'hffff_ffff);
		reg_rd(BASE, 32'h1f, 1'b1);
		reg_rd(BASE + 32'h4, 32'h0, 1'b0);
		foreach (rows[i]) begin
			reg_wr({27'h0, rows[i].ctrl});
			oaddr <= 32'h1234_5670 + i;
			odata <= 32'h00ff_0103 << i;
			oam <= 6'h0d + 6'(i);
			repeat (3) @(posedge clk);
			#1 chk({28'h0, a_par}, par4(oaddr, rows[i].fa));
			chk({31'h0, am_par}, {31'h0, ~^oam ^ rows[i].fa});
			chk({28'h0, d_par}, par4(odata, rows[i].fd));
			chk({31'h0, fe_ok}, {31'h0, rows[i].fe});
		end
		reg_wr(32'h0);
		bad_a <= 1'b1;
		strobe(3'h4);
		bad_a <= 1'b0;
		#1 chk({31'h0, irq}, 32'h0);
		reg_rd(BASE, 32'h20, 1'b1);
		reg_wr(32'h2);
		bad_d <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk({31'h0, irq}, 32'h1);
		strobe(3'h2);
		reg_rd(BASE, 32'h22, 1'b1);
		inv_w <= 1'b1;
		bdrv <= 1'b1;
		strobe(3'h2);
		reg_rd(BASE, 32'h22, 1'b1);
		bdrv <= 1'b0;
		strobe(3'h2);
		reg_rd(BASE, 32'h62, 1'b1);
		reg_wr(32'h802);
		reg_rd(BASE, 32'h02, 1'b1);
		#1 chk({31'h0, irq}, 32'h0);
		@(posedge clk);
		inv_w <= 1'b0;
		inv_r <= 1'b1;
		strobe(3'h1);
		reg_rd(BASE, 32'h42, 1'b1);
		brst_n <= 1'b0;
		repeat (8) @(posedge clk);
		brst_n <= 1'b1;
		repeat (2) @(posedge clk);
		reg_rd(BASE, 32'h0, 1'b1);
		a24 <= 1'b1;
		reg_rd({8'hff, BASE[23:0]}, 32'h0, 1'b1);
		blk <= 1'b1;
		stb_n <= 3'h3;
		repeat (8) @(posedge clk);
		bad_a <= 1'b1;
		repeat (4) @(posedge clk);
		stb_n <= 3'h7;
		bad_a <= 1'b0;
		repeat (8) @(posedge clk);
		reg_rd(BASE, 32'h0, 1'b1);
		bad_a <= 1'b1;
		strobe(3'h4);
		reg_rd(BASE, 32'h20, 1'b1);
		end_of_test();
	end
endmodule
